// ===== rtl/rcs_pkg.sv
// constants for the two-channel memory channel select and configuration block
package rcs_pkg;

  // ==========================================================
  // register offsets (byte addresses on the local register port)
  localparam logic [11:0] OFS_CH0_CONTROL = 12'h000;
  localparam logic [11:0] OFS_CH0_MASK = 12'h004;
  localparam logic [11:0] OFS_CH1_CONTROL = 12'h100;
  localparam logic [11:0] OFS_CH1_MASK = 12'h104;

  // ==========================================================
  // control register field positions
  localparam int BASE_MSB = 31;
  localparam int BASE_LSB = 20;
  localparam int PSIZE_MSB = 14;
  localparam int PSIZE_LSB = 13;
  localparam int PWAIT_MSB = 12;
  localparam int PWAIT_LSB = 11;
  localparam int NWAIT_MSB = 10;
  localparam int NWAIT_LSB = 8;
  localparam int SIZE_MSB = 6;
  localparam int SIZE_LSB = 4;
  localparam int NARROW_BIT = 2;
  localparam int RSVD_BIT = 1;
  localparam int PAGE_ROM_BIT = 0;

  // writable bits of a control register; reserved bit 1 is held at zero
  localparam logic [31:0] CTL_WRITE_MASK = 32'hfff0_7f75;
  // writable bits of a mask register
  localparam logic [31:0] MASK_WRITE_MASK = 32'hfff0_0000;

  // ==========================================================
  // values after reset
  // channel 0: base 0x1fc, size code 101 (32 Mbytes), width from strap
  localparam logic [31:0] CTL0_RESET = 32'h1fc0_0050;
  localparam logic [31:0] CTL1_RESET = 32'h0000_0000;
  localparam logic [11:0] MASK_RESET = 12'h000;

  // ==========================================================
  // size codes and burst step
  localparam logic [2:0] SIZE_8MB = 3'h3;
  localparam logic [2:0] SIZE_MAX = 3'h5;
  localparam logic [3:0] NIBBLE_DOWN = 4'hc;
  localparam logic [31:0] BURST_STEP = 32'h0000_0004;

  // ==========================================================
  // all state of the select block
  typedef struct packed {
    logic [31:0] ctl0;          // channel 0 control
    logic [31:0] ctl1;          // channel 1 control
    logic [11:0] mask0;         // channel 0 compare mask
    logic [11:0] mask1;         // channel 1 compare mask
    logic strap_done;           // width strap already taken
    logic [31:0] rdata;         // read data, one cycle after strobe
    logic sel0;                 // channel 0 selected
    logic sel1;                 // channel 1 selected
    logic sel_none;             // valid access hit no channel
    logic bank1;                // bank 1 chosen
    logic two_cycles;           // two bus cycles needed
    logic [2:0] nwait;          // selected normal wait
    logic [1:0] pwait;          // selected page wait
    logic psize8;               // selected page size is eight words
    logic narrow;               // selected channel is 16 bits wide
    logic page_rom;             // selected channel is page-mode rom
    logic [31:0] burst_addr;    // generated burst address
    logic burst_down;           // burst counts downward
  } rcs_state_t;

endpackage : rcs_pkg

// ===== rtl/rcs_rom_channel_select.sv
// channel select, bank select and configuration registers of the rom channels
//
// Notes on behaviour
// - channel 1 base in control bits 31:20
// - page size: 00 four, 01 eight words
// - page wait 0..3, also interleave waits
// - normal wait 0..6, code 111 reserved
// - size codes 1 to 32 Mbytes
// - bit 2 set means 16-bit bus
// - bit 0 set marks page-mode rom
// - mask bit set drops base bit compare
// - select channel on unmasked base match
// - compare only bits above channel size
// - two banks, bit below compare range
// - channel 0 large sizes reverse banks
// - double match: higher base wins
// - equal bases: channel 0 wins
// - channel 0 base resets to 0x1fc
// - channel 0 size resets to 32 Mbytes
// - channel 0 control uses same layout
// - channel 0 width taken from strap
// - narrow channel: word takes two cycles
// - burst address counts up or down
`timescale 1ns/1ps

module rcs_rom_channel_select
(
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // boot width strap
  input wire logic boot_width_pin,
  // internal system bus address phase
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0] bus_byte_en,
  input wire logic burst_start,
  input wire logic burst_step,
  // select results, one cycle after bus_valid
  output logic sel_ch0,
  output logic sel_ch1,
  output logic sel_none,
  output logic bank1_sel,
  output logic two_bus_cycles,
  output logic [2:0] sel_normal_wait,
  output logic [1:0] sel_page_wait,
  output logic sel_page_size8,
  output logic sel_narrow_bus,
  output logic sel_page_rom,
  // interleave wait of channel 1
  output logic [1:0] ch1_interleave_wait,
  // burst address generator
  output logic [31:0] burst_addr
);

  // ==========================================================
  // state
  rcs_pkg::rcs_state_t st_r;   // registered state
  rcs_pkg::rcs_state_t st_nxt; // next state

  // ==========================================================
  // helper functions

  // reserved size codes 11x behave as the largest size
  // size code clamp
  function automatic logic [2:0] size_code(input logic [31:0] ctl);
    logic [2:0] c;
    c = ctl[rcs_pkg::SIZE_MSB:rcs_pkg::SIZE_LSB];
    if (c > rcs_pkg::SIZE_MAX)
      c = rcs_pkg::SIZE_MAX;
    return c;
  endfunction : size_code

  // true when the upper address bits hit the channel window
  function automatic logic window_hit(input logic [31:0] addr,
                                      input logic [31:0] ctl,
                                      input logic [11:0] mask);
    logic [11:0] range;
    logic [11:0] base;
    range = 12'hfff << size_code(ctl);
    base = ctl[rcs_pkg::BASE_MSB:rcs_pkg::BASE_LSB];
    range = range & ~mask;
    return ((addr[31:20] ^ base) & range) == 12'h000;
  endfunction : window_hit

  // address bit just below the compared range
  function automatic logic bank_bit(input logic [31:0] addr,
                                    input logic [31:0] ctl);
    logic [4:0] pos;
    pos = 5'h13 + {2'h0, size_code(ctl)};
    return addr[pos];
  endfunction : bank_bit

  // register value as read back
  function automatic logic [31:0] read_mux(input logic [11:0] a,
                                           input rcs_pkg::rcs_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      rcs_pkg::OFS_CH0_CONTROL: v = s.ctl0;
      rcs_pkg::OFS_CH1_CONTROL: v = s.ctl1;
      rcs_pkg::OFS_CH0_MASK: v = {s.mask0, 20'h00000};
      rcs_pkg::OFS_CH1_MASK: v = {s.mask1, 20'h00000};
      default: v = 32'h0000_0000; // unmapped reads zero
    endcase
    return v;
  endfunction : read_mux

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic hit0;
    logic hit1;
    logic pick1;
    logic bnk;
    logic [31:0] csel;
    logic [2:0] ones;
    hit0 = 1'b0;
    hit1 = 1'b0;
    pick1 = 1'b0;
    bnk = 1'b0;
    csel = 32'h0000_0000;
    ones = 3'h0;
    st_nxt = st_r;

    if (!st_r.strap_done)
    begin
      st_nxt.strap_done = 1'b1;
      st_nxt.ctl0[rcs_pkg::NARROW_BIT] = boot_width_pin;
    end

    // software writes; a later write overrides the strap
    if (reg_write)
    begin
      case (reg_addr)
        rcs_pkg::OFS_CH0_CONTROL:
        begin
          st_nxt.ctl0 = reg_wdata & rcs_pkg::CTL_WRITE_MASK;
        end
        rcs_pkg::OFS_CH1_CONTROL:
        begin
          st_nxt.ctl1 = reg_wdata & rcs_pkg::CTL_WRITE_MASK;
        end
        rcs_pkg::OFS_CH0_MASK:
        begin
          st_nxt.mask0 = reg_wdata[31:20];
        end
        rcs_pkg::OFS_CH1_MASK:
        begin
          st_nxt.mask1 = reg_wdata[31:20];
        end
        default:
        begin
          // unmapped writes are dropped
        end
      endcase
    end

    // read data stand only in the cycle after the strobe
    st_nxt.rdata = reg_read ? read_mux(reg_addr, st_r) : 32'h0000_0000;

    // channel decode
    hit0 = bus_valid && window_hit(bus_addr, st_r.ctl0, st_r.mask0);
    hit1 = bus_valid && window_hit(bus_addr, st_r.ctl1, st_r.mask1);
    if (hit0 && hit1)
    begin
      pick1 = st_r.ctl1[rcs_pkg::BASE_MSB:rcs_pkg::BASE_LSB] >
              st_r.ctl0[rcs_pkg::BASE_MSB:rcs_pkg::BASE_LSB];
    end
    else
    begin
      pick1 = hit1;
    end
    csel = pick1 ? st_r.ctl1 : st_r.ctl0;

    // bank decode
    bnk = bank_bit(bus_addr, csel);
    if (!pick1 && size_code(st_r.ctl0) >= rcs_pkg::SIZE_8MB)
      bnk = ~bnk;

    st_nxt.sel0 = (hit0 || hit1) && !pick1;
    st_nxt.sel1 = pick1;
    st_nxt.sel_none = bus_valid && !hit0 && !hit1;
    st_nxt.bank1 = (hit0 || hit1) && bnk;

    ones = {2'h0, bus_byte_en[0]} + {2'h0, bus_byte_en[1]} +
           {2'h0, bus_byte_en[2]} + {2'h0, bus_byte_en[3]};
    st_nxt.two_cycles = (hit0 || hit1) && csel[rcs_pkg::NARROW_BIT] &&
                        (ones >= 3'h3);

    // timing of the chosen channel, zero on a miss
    if (hit0 || hit1)
    begin
      st_nxt.nwait = csel[rcs_pkg::NWAIT_MSB:rcs_pkg::NWAIT_LSB];
      st_nxt.pwait = csel[rcs_pkg::PWAIT_MSB:rcs_pkg::PWAIT_LSB];
      st_nxt.psize8 = csel[rcs_pkg::PSIZE_LSB];
      st_nxt.narrow = csel[rcs_pkg::NARROW_BIT];
      st_nxt.page_rom = csel[rcs_pkg::PAGE_ROM_BIT];
    end
    else
    begin
      st_nxt.nwait = 3'h0;
      st_nxt.pwait = 2'h0;
      st_nxt.psize8 = 1'b0;
      st_nxt.narrow = 1'b0;
      st_nxt.page_rom = 1'b0;
    end

    if (burst_start)
    begin
      st_nxt.burst_addr = bus_addr;
      st_nxt.burst_down = bus_addr[3:0] == rcs_pkg::NIBBLE_DOWN;
    end
    else if (burst_step)
    begin
      // other start nibbles count upward
      st_nxt.burst_addr = st_r.burst_down ?
                          st_r.burst_addr - rcs_pkg::BURST_STEP :
                          st_r.burst_addr + rcs_pkg::BURST_STEP;
    end
  end

  // ==========================================================
  // state register; reset loads constants only, strap comes after
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
      st_r.ctl0 <= rcs_pkg::CTL0_RESET;
      st_r.ctl1 <= rcs_pkg::CTL1_RESET;
      st_r.mask0 <= rcs_pkg::MASK_RESET;
      st_r.mask1 <= rcs_pkg::MASK_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign reg_rdata = st_r.rdata;
  assign sel_ch0 = st_r.sel0;
  assign sel_ch1 = st_r.sel1;
  assign sel_none = st_r.sel_none;
  assign bank1_sel = st_r.bank1;
  assign two_bus_cycles = st_r.two_cycles;
  assign sel_normal_wait = st_r.nwait;
  assign sel_page_wait = st_r.pwait;
  assign sel_page_size8 = st_r.psize8;
  assign sel_narrow_bus = st_r.narrow;
  assign sel_page_rom = st_r.page_rom;
  assign ch1_interleave_wait =
    st_r.ctl1[rcs_pkg::PWAIT_MSB:rcs_pkg::PWAIT_LSB];
  assign burst_addr = st_r.burst_addr;

endmodule : rcs_rom_channel_select

// ===== test/rcs_rom_channel_select_sva.sv
// checker for the rom channel select block
`timescale 1ns/1ps

module rcs_rom_channel_select_sva
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic bus_valid,
  input wire logic [31:0] bus_addr,
  input wire logic burst_start,
  input wire logic sel_ch0,
  input wire logic sel_ch1,
  input wire logic sel_none,
  input wire logic bank1_sel,
  input wire logic two_bus_cycles,
  input wire logic [2:0] sel_normal_wait,
  input wire logic sel_narrow_bus,
  input wire logic [1:0] ch1_interleave_wait,
  input wire logic [31:0] burst_addr
);
  // ==========================================
  // one clock domain, reset disables all
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  chk_hit_onehot: assert property (bus_valid |=>
    $onehot({sel_ch0, sel_ch1, sel_none})) else $error("select not one-hot");
  chk_idle_quiet: assert property (!bus_valid |=>
    !(sel_ch0 || sel_ch1 || sel_none)) else $error("select without access");
  chk_miss_quiet: assert property (sel_none |->
    !bank1_sel && sel_normal_wait == 3'h0 && !two_bus_cycles)
    else $error("miss carries timing");
  chk_two_narrow: assert property (two_bus_cycles |->
    sel_narrow_bus && !sel_none) else $error("split on wide bus");
  chk_burst_load: assert property (burst_start |=>
    burst_addr == $past(bus_addr)) else $error("burst start not loaded");
  chk_ilv_wait: assert property (reg_write && reg_addr == 12'h100 |=>
    ch1_interleave_wait == $past(reg_wdata[12:11]))
    else $error("interleave wait not updated");
  chk_rdata_idle: assert property (!reg_read |=>
    reg_rdata == 32'h0000_0000) else $error("read data outside slot");
  chk_ctl_rsvd: assert property (reg_read && reg_addr[7:0] == 8'h00
    && !reg_addr[11:9] |=> reg_rdata[1] == 1'b0 && reg_rdata[19:15] == 5'h00)
    else $error("reserved control bits set");
  chk_mask_low: assert property (reg_read && reg_addr == 12'h004 |=>
    reg_rdata[19:0] == 20'h0_0000) else $error("mask low bits set");

  // ==========================================
  // main scenarios reached
  cov_ch1: cover property (bus_valid ##1 sel_ch1);
  cov_miss: cover property (sel_none);
  cov_split: cover property (two_bus_cycles && bank1_sel);
endmodule : rcs_rom_channel_select_sva

bind rcs_rom_channel_select rcs_rom_channel_select_sva chk (.*);

// ===== test/rcs_bus_master.sv
// internal bus master model driving address phases and burst controls
`timescale 1ns/1ps

module rcs_bus_master
(
  input wire logic clk_sys,
  output logic bus_valid,
  output logic [31:0] bus_addr,
  output logic [3:0] bus_byte_en,
  output logic burst_start,
  output logic burst_step
);
  // ==========================================
  // idle at time zero
  initial
  begin
    bus_valid = 1'b0;
    bus_addr = 32'h0000_0000;
    bus_byte_en = 4'h0;
    burst_start = 1'b0;
    burst_step = 1'b0;
  end

  // one request cycle; kind 0 access, 1 burst start, 2 burst step
  task automatic drive(input logic [31:0] a, input logic [3:0] be,
                       input int kind);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_byte_en <= be;
    bus_valid <= (kind == 0);
    burst_start <= (kind == 1);
    burst_step <= (kind == 2);
    @(posedge clk_sys);
    bus_valid <= 1'b0;
    burst_start <= 1'b0;
    burst_step <= 1'b0;
    // released lines must not keep the last value
    bus_addr <= ~a;
    bus_byte_en <= ~be;
  endtask : drive
endmodule : rcs_bus_master

// ===== test/tb_top.sv
// self-checking bench for the rom channel select block
`timescale 1ns/1ps

module tb_top;
  logic clk_sys, reset_n, reg_write, reg_read, boot_width_pin;
  logic bus_valid, burst_start, burst_step, sel_ch0, sel_ch1, sel_none;
  logic bank1_sel, two_bus_cycles, sel_page_size8, sel_narrow_bus;
  logic sel_page_rom;
  logic [1:0] sel_page_wait, ch1_interleave_wait;
  logic [2:0] sel_normal_wait;
  logic [3:0] bus_byte_en;
  logic [11:0] reg_addr, m0, m1;
  logic [31:0] reg_wdata, reg_rdata, bus_addr, burst_addr, c0, c1, a, v;
  integer seed = 55;
  integer n_errors = 0;
  integer checks_done = 0;
  integer i, k;

  rcs_rom_channel_select DUT (.*);
  rcs_bus_master pm (.*);

  // ==========================================
  // clock generator, 5 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask : rd

  // expected decode from the current register image
  function automatic logic [12:0] ref_dec(input logic [31:0] ad,
                                          input logic [3:0] be);
    logic h0, h1, p1, b;
    logic [31:0] c;
    h0 = ((ad[31:20] ^ c0[31:20]) & ~m0 & (12'hfff << c0[6:4])) == 12'h000;
    h1 = ((ad[31:20] ^ c1[31:20]) & ~m1 & (12'hfff << c1[6:4])) == 12'h000;
    p1 = h1 && (!h0 || c1[31:20] > c0[31:20]);
    c = p1 ? c1 : c0;
    b = ad[19 + c[6:4]] ^ (!p1 && c[6:4] >= 3'h3);
    if (!h0 && !h1)
      return 13'h0400;
    return {!p1, p1, 1'b0, b, c[2] && $countones(be) >= 3, c[10:8],
            c[12:11], c[13], c[2], c[0]};
  endfunction : ref_dec

  task automatic dec(input logic [31:0] ad, input logic [3:0] be);
    pm.drive(ad, be, 0);
    #1;
    chk("select", {19'h0, ref_dec(ad, be)}, {19'h0, sel_ch0, sel_ch1,
        sel_none, bank1_sel, two_bus_cycles, sel_normal_wait,
        sel_page_wait, sel_page_size8, sel_narrow_bus, sel_page_rom});
  endtask : dec

  // random legal control word, reserved bit kept clear
  function automatic logic [31:0] rcfg();
    logic [31:0] r;
    r = $random(seed) & 32'hfff0_3f75;
    if (r[10:8] == 3'h7)
      r[10:8] = 3'h6;
    if (r[6:4] > 3'h5)
      r[6:4] = r[6:4] - 3'h2;
    return r;
  endfunction : rcfg

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // ==========================================
  // hang guard
  initial
  begin
    #100000;
    n_errors++;
    print_verdict;
  end

  // ==========================================
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    boot_width_pin = 1'b1;
    c0 = 32'h1fc0_0054;
    c1 = 32'h0000_0000;
    m0 = 12'h000;
    m1 = 12'h000;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(rcs_pkg::OFS_CH0_CONTROL, c0);
    rd(rcs_pkg::OFS_CH0_MASK, 32'h0000_0000);
    rd(rcs_pkg::OFS_CH1_MASK, 32'h0000_0000);
    rd(rcs_pkg::OFS_CH1_CONTROL, c1);
    dec(32'h1fc0_0000, 4'hf);
    dec(32'h1e00_0000, 4'h3);
    dec(32'h0008_0000, 4'hf);
    dec(32'h8000_0000, 4'h1);
    wr(12'h008, 32'hffff_ffff);
    rd(12'h008, 32'h0000_0000);
    for (i = 0; i < 40; i++)
    begin
      c0 = rcfg();
      c1 = rcfg();
      if (i % 4 == 0)
        c1[31:20] = c0[31:20];
      v = $random(seed) & $random(seed);
      m0 = v[31:20] & v[11:0];
      m1 = v[23:12] & v[19:8];
      wr(rcs_pkg::OFS_CH0_CONTROL, c0);
      wr(rcs_pkg::OFS_CH1_CONTROL, c1);
      wr(rcs_pkg::OFS_CH0_MASK, {m0, 20'h0_0000});
      wr(rcs_pkg::OFS_CH1_MASK, {m1, 20'h0_0000});
      rd(rcs_pkg::OFS_CH0_CONTROL, c0);
      rd(rcs_pkg::OFS_CH1_MASK, {m1, 20'h0_0000});
      chk("ilv_wait", {30'h0, c1[12:11]}, {30'h0, ch1_interleave_wait});
      for (k = 0; k < 8; k++)
      begin
        a = $random(seed);
        if (k < 6)
          a[31:20] = (k % 2) ? c1[31:20] : c0[31:20];
        v = $random(seed);
        dec(a, v[3:0]);
      end
    end
    for (i = 0; i < 2; i++)
    begin
      a = i ? 32'h2000_0000 : 32'h0000_100c;
      pm.drive(a, 4'h0, 1);
      for (k = 0; k < 4; k++)
      begin
        if (k > 0)
          pm.drive(a, 4'h0, 2);
        #1;
        v = i ? a + 4 * k : a - 4 * k;
        chk("burst_addr", v, burst_addr);
      end
    end
    print_verdict;
  end
endmodule : tb_top
